/* File: hw/spi_eeprom_ctrl.v */
// Serial EEPROM command controller: decode, status, read and page write
// How it works
// - Opcode 04h clears latch, then wait deselect.
// - Latch clears at reset, 04h, write end.
// - Status write: 01h plus one byte, latch set.
// - Status write needs deselect at byte boundary.
// - Status write runs timed cycle, busy flag set.
// - Status write changes only lock and protect.
// - Protect pair selects none, quarter, half, whole.
// - Lock bit clear: latch alone permits status write.
// - Lock set and pin low refuses status write.
// - Protection follows pin level, left only high.
// - Array read: 03h, two address bytes, A15 ignored.
// - Read increments address, wraps at array end.
// - Array read refused during write cycle.
// - Array write ignored when latch clear.
// - Byte write: 02h, address, one data byte.
// - Write starts only outside protected blocks.
// - Page write loads up to 64 bytes.
// - Page load wraps six low address bits.
// - Only status read accepted while busy.
// - Id read: 83h, A10 clear, A5:A0 byte.
// - Id read wraps in page, refused busy.
// - Opcode 06h alone sets the write latch.
// - Status byte layout; bits 6:4 read zero.
// - Status read repeats status byte while selected.
// - Commands start on select, MSB first.
`timescale 1ns/1ps
`include "spi_eeprom_regs.vh"

module spi_eeprom_ctrl #(
  parameter AW     = 15,
  parameter PW     = 6,
  parameter WC_CYC = (`WC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)(
  input  wire          clk_sys,
  input  wire          rstn,
  input  wire          ce,
  input  wire          cs_n,
  input  wire          sck,
  input  wire          mosi,
  input  wire          wp_n,
  input  wire [7:0]    mem_rdata,
  output reg           miso,
  output reg           miso_oe,
  output reg           mem_rd,
  output reg           mem_id,
  output reg           mem_wr,
  output reg  [AW-1:0] mem_addr,
  output reg  [7:0]    mem_wdata,
  output reg           write_busy_flag,
  output reg           write_enable_latch
);

  ////////////////////////////////////////////////////////////////////
  // States, one-hot
  localparam [6:0] S_CMD  = 7'h01;  // Waiting for opcode
  localparam [6:0] S_ADDR = 7'h02;  // Taking address bytes
  localparam [6:0] S_RD   = 7'h04;  // Shifting out array or id data
  localparam [6:0] S_SR   = 7'h08;  // Shifting out status byte
  localparam [6:0] S_WRS  = 7'h10;  // Taking status data byte
  localparam [6:0] S_WRA  = 7'h20;  // Taking page data bytes
  localparam [6:0] S_WAIT = 7'h40;  // Ignoring input until deselect
  localparam [7:0] SR_RST = `SR_INIT;  // Status value after reset

  ////////////////////////////////////////////////////////////////////
  // Functions

  // Address range locked by the block-protect pair
  function prot_hit;
    input [1:0]    bp_f;
    input [AW-1:0] a;
    begin
      case (bp_f)
        `BP_QUARTER: prot_hit = (a[AW-1:AW-2] == 2'h3);
        `BP_HALF:    prot_hit = a[AW-1];
        `BP_WHOLE:   prot_hit = 1'b1;
        default:     prot_hit = 1'b0;
      endcase
    end
  endfunction

  // Next address; in page mode only the low bits move
  function [AW-1:0] next_addr;
    input [AW-1:0] a;
    input          in_page;
    begin
      if (in_page)
        next_addr = {a[AW-1:PW], a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
      else
        next_addr = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg           cs_m, cs_s, cs_d;     // Select synchroniser and history
  reg           sck_m, sck_s, sck_d;  // Clock synchroniser and history
  reg           mosi_m, mosi_s;       // Data synchroniser
  reg           wp_m, wp_s;           // Write-protect synchroniser
  reg  [6:0]    state;                // Command state
  reg  [6:0]    rx_sh;                // Bits of the byte in flight
  reg  [2:0]    bit_cnt;              // Bit within byte
  reg  [2:0]    nbytes;               // Whole bytes taken, saturates
  reg           cmd_rd;               // Address phase leads to a read
  reg           cmd_id;               // Read targets the id page
  reg  [AW-1:0] addr;                 // Internal address counter
  reg  [7:0]    data_reg;             // Read byte or pending status
  reg  [2:0]    oidx;                 // Output bit index
  reg           rd_pend;              // Memory answer due this cycle
  reg           status_lock_bit;      // Non-volatile status lock
  reg           block_protect_hi;     // Non-volatile protect, high
  reg           block_protect_lo;     // Non-volatile protect, low
  reg  [31:0]   wc_cnt;               // Write cycle down-counter
  reg  [PW-1:0] fl_idx;               // Page flush index
  reg           flushing;             // Page flush running
  reg  [AW-PW-1:0] wr_page;           // Page being committed
  reg  [63:0]   pvalid;               // Page bytes loaded
  reg  [7:0]    pbuf [0:63];          // Page load buffer

  ////////////////////////////////////////////////////////////////////
  // Combinational terms
  wire       sck_rise  = sck_s & ~sck_d;
  wire       sck_fall  = ~sck_s & sck_d;
  wire       cs_rise   = cs_s & ~cs_d;
  wire       byte_done = sck_rise & (bit_cnt == 3'h7);
  wire [7:0] rx_byte   = {rx_sh, mosi_s};
  wire [1:0] bp        = {block_protect_hi, block_protect_lo};

  // Status byte as read; bits 6:4 are tied low
  wire [7:0] status = {status_lock_bit, 3'h0, bp,
                       write_enable_latch, write_busy_flag};

  // Pin level is looked at live, so protection holds only while low
  wire sr_ok = write_enable_latch &
               ~(status_lock_bit & ~wp_s);

  // Byte driven on the output line
  wire [7:0] out_byte = state[3] ? status : data_reg;

  // Page buffer load strobe
  wire buf_wr = ce & ~cs_s & byte_done & state[5];

  ////////////////////////////////////////////////////////////////////
  // Page buffer storage, no reset needed: validity is tracked apart
  always @(posedge clk_sys)
  begin
    if (buf_wr)
      pbuf[addr[PW-1:0]] <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////
  // Main control process
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_m               <= 1'b1;
      cs_s               <= 1'b1;
      cs_d               <= 1'b1;
      sck_m              <= 1'b0;
      sck_s              <= 1'b0;
      sck_d              <= 1'b0;
      mosi_m             <= 1'b0;
      mosi_s             <= 1'b0;
      wp_m               <= 1'b0;
      wp_s               <= 1'b0;
      state              <= S_CMD;
      rx_sh              <= 7'h00;
      bit_cnt            <= 3'h0;
      nbytes             <= 3'h0;
      cmd_rd             <= 1'b0;
      cmd_id             <= 1'b0;
      addr               <= {AW{1'b0}};
      data_reg           <= 8'h00;
      oidx               <= 3'h0;
      rd_pend            <= 1'b0;
      status_lock_bit    <= SR_RST[`SR_LOCK_BIT];
      block_protect_hi   <= SR_RST[`SR_BP_HI_BIT];
      block_protect_lo   <= SR_RST[`SR_BP_LO_BIT];
      wc_cnt             <= 32'h0000_0000;
      fl_idx             <= {PW{1'b0}};
      flushing           <= 1'b0;
      wr_page            <= {(AW-PW){1'b0}};
      pvalid             <= 64'h0000_0000_0000_0000;
      miso               <= 1'b0;
      miso_oe            <= 1'b0;
      mem_rd             <= 1'b0;
      mem_id             <= 1'b0;
      mem_wr             <= 1'b0;
      mem_addr           <= {AW{1'b0}};
      mem_wdata          <= 8'h00;
      write_busy_flag    <= 1'b0;
      write_enable_latch <= 1'b0;
    end
    else if (ce)
    begin
      // Pins pass two flops before use
      cs_m   <= cs_n;
      cs_s   <= cs_m;
      cs_d   <= cs_s;
      sck_m  <= sck;
      sck_s  <= sck_m;
      sck_d  <= sck_s;
      mosi_m <= mosi;
      mosi_s <= mosi_m;
      wp_m   <= wp_n;
      wp_s   <= wp_m;

      // Strobes last one cycle
      mem_rd  <= 1'b0;
      mem_wr  <= 1'b0;
      rd_pend <= mem_rd;
      if (rd_pend)
        data_reg <= mem_rdata;

      // Self-timed write cycle: busy for exactly WC_CYC cycles
      if (write_busy_flag)
      begin
        if (wc_cnt == 32'h0000_0000)
        begin
          write_busy_flag    <= 1'b0;
          write_enable_latch <= 1'b0;
        end
        else
          wc_cnt <= wc_cnt - 32'h0000_0001;
      end

      // Commit loaded bytes of the page, one per cycle
      if (flushing)
      begin
        if (pvalid[fl_idx])
        begin
          mem_wr    <= 1'b1;
          mem_addr  <= {wr_page, fl_idx};
          mem_wdata <= pbuf[fl_idx];
        end
        fl_idx <= fl_idx + {{(PW-1){1'b0}}, 1'b1};
        if (&fl_idx)
          flushing <= 1'b0;
      end

      if (cs_s)
      begin
        // Deselected: every command restarts from the opcode
        state   <= S_CMD;
        bit_cnt <= 3'h0;
        nbytes  <= 3'h0;
        oidx    <= 3'h0;
        miso    <= 1'b0;
        miso_oe <= 1'b0;
        // Deselect on a byte boundary commits a write
        if (cs_rise && bit_cnt == 3'h0)
        begin
          // Exactly one data byte, else discarded
          if (state[4] && nbytes == 3'h2 && sr_ok)
          begin
            status_lock_bit  <= data_reg[`SR_LOCK_BIT];
            block_protect_hi <= data_reg[`SR_BP_HI_BIT];
            block_protect_lo <= data_reg[`SR_BP_LO_BIT];
            write_busy_flag  <= 1'b1;
            wc_cnt           <= WC_CYC - 1;
          end
          // Opcode, two address bytes and at least one data byte
          if (state[5] && nbytes >= 3'h4 && !prot_hit(bp, addr))
          begin
            write_busy_flag <= 1'b1;
            wc_cnt          <= WC_CYC - 1;
            flushing        <= 1'b1;
            fl_idx          <= {PW{1'b0}};
            wr_page         <= addr[AW-1:PW];
          end
        end
      end
      else
      begin
        // Input taken on rising clock, MSB first
        if (sck_rise)
        begin
          rx_sh   <= rx_byte[6:0];
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7 && nbytes != 3'h7)
            nbytes <= nbytes + 3'h1;
        end

        if (byte_done)
        begin
          case (state)
            S_CMD:
            begin
              if (write_busy_flag)
                // Only the status read gets through a write cycle
                state <= (rx_byte == `OP_STATUS_READ) ? S_SR : S_WAIT;
              else
              begin
                case (rx_byte)
                  `OP_SET_LATCH:
                  begin
                    write_enable_latch <= 1'b1;
                    state              <= S_WAIT;
                  end
                  `OP_CLEAR_LATCH:
                  begin
                    write_enable_latch <= 1'b0;
                    state              <= S_WAIT;
                  end
                  `OP_STATUS_READ:
                    state <= S_SR;
                  `OP_STATUS_WRITE:
                    state <= write_enable_latch ? S_WRS : S_WAIT;
                  `OP_ARRAY_READ:
                  begin
                    cmd_rd <= 1'b1;
                    cmd_id <= 1'b0;
                    state  <= S_ADDR;
                  end
                  `OP_ID_READ:
                  begin
                    cmd_rd <= 1'b1;
                    cmd_id <= 1'b1;
                    state  <= S_ADDR;
                  end
                  `OP_ARRAY_WRITE:
                  begin
                    // Without the latch the write is ignored
                    cmd_rd <= 1'b0;
                    cmd_id <= 1'b0;
                    pvalid <= 64'h0000_0000_0000_0000;
                    state  <= write_enable_latch ? S_ADDR : S_WAIT;
                  end
                  default:
                    state <= S_WAIT;  // Unknown opcode
                endcase
              end
            end
            S_ADDR:
            begin
              if (nbytes == 3'h1)
              begin
                // High byte; the top address bit is dropped
                addr[AW-1:8] <= rx_byte[AW-9:0];
                // Id page read needs A10 low; lock read not handled
                if (cmd_id && rx_byte[`ID_SEL_BIT-8])
                  state <= S_WAIT;
              end
              else
              begin
                addr[7:0] <= rx_byte;
                if (cmd_rd)
                begin
                  // Fetch the first byte well before the first fall
                  mem_rd   <= 1'b1;
                  mem_id   <= cmd_id;
                  mem_addr <= {addr[AW-1:8], rx_byte};
                  state    <= S_RD;
                end
                else
                  state <= S_WRA;
              end
            end
            S_WRS:
              data_reg <= rx_byte;  // Held until deselect
            S_WRA:
            begin
              // Low bits only, so a long load overwrites the page start
              pvalid[addr[PW-1:0]] <= 1'b1;
              addr <= next_addr(addr, 1'b1);
            end
            default:
              ;
          endcase
        end

        // Output driven on falling clock
        if (sck_fall && (state[2] || state[3]))
        begin
          miso_oe <= 1'b1;
          miso    <= out_byte[3'h7 - oidx];
          oidx    <= oidx + 3'h1;
          if (oidx == 3'h7 && state[2])
          begin
            // Array reads wrap at the top, id reads inside the page
            addr     <= next_addr(addr, cmd_id);
            mem_rd   <= 1'b1;
            mem_addr <= next_addr(addr, cmd_id);
          end
        end
      end
    end
  end

endmodule

/* File: hw/spi_eeprom_regs.vh */
// Constants for the serial EEPROM command controller
`ifndef SPI_EEPROM_REGS_VH
`define SPI_EEPROM_REGS_VH

// Command opcodes
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_WRITE  8'h02
`define OP_ARRAY_READ   8'h03
`define OP_CLEAR_LATCH  8'h04
`define OP_STATUS_READ  8'h05
`define OP_SET_LATCH    8'h06
`define OP_ID_READ      8'h83

// Status byte bit positions
`define SR_BUSY_BIT     0
`define SR_WEL_BIT      1
`define SR_BP_LO_BIT    2
`define SR_BP_HI_BIT    3
`define SR_LOCK_BIT     7

// Status value after reset (non-volatile bits)
`define SR_INIT         8'h00

// Address bit that must be clear for an id page read
`define ID_SEL_BIT      10

// Block-protect codes
`define BP_NONE         2'h0
`define BP_QUARTER      2'h1
`define BP_HALF         2'h2
`define BP_WHOLE        2'h3

// Self-timed write cycle and system clock
`define WC_TIME_NS      5000
`define CLK_PERIOD_NS   5

`endif

/* File: test/spi_eeprom_ctrl_assertions.sv */
// Checker for the serial EEPROM command controller ports
`timescale 1ns/1ps
module spi_eeprom_ctrl_chk #(
  parameter WC_CYC = 1000
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic miso_oe,
  input wire logic write_busy_flag,
  input wire logic write_enable_latch
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // Length of the running write cycle, 0 on its first sampled cycle
  logic [15:0] busy_cnt;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= write_busy_flag ? busy_cnt + 16'h0001 : 16'h0000;
  ////////////////////////////////////////////////////////////////////////
  busy_len_a: assert property ($fell(write_busy_flag) |-> busy_cnt == WC_CYC)
    else $error("write cycle length wrong");
  latch_end_a: assert property ($fell(write_busy_flag) |-> !write_enable_latch)
    else $error("latch not cleared at write end");
  busy_start_a: assert property ($rose(write_busy_flag) |-> $past(cs_n, 2))
    else $error("write cycle began while selected");
  wr_in_cycle_a: assert property (mem_wr |-> write_busy_flag && busy_cnt <= 16'd65)
    else $error("array write outside early write cycle");
  rd_idle_a: assert property (mem_rd |-> !write_busy_flag)
    else $error("array read during write cycle");
  rd_pulse_a: assert property (mem_rd |=> !mem_rd)
    else $error("read strobe longer than one cycle");
  oe_release_a: assert property (cs_n [*6] |-> !miso_oe)
    else $error("output driven while deselected");
  latch_set_a: assert property ($rose(write_enable_latch) |-> !$past(cs_n) && !$past(write_busy_flag))
    else $error("latch set outside a command");
  busy_cover: cover property ($rose(write_busy_flag));
  wr_cover: cover property (mem_wr);
  rd_cover: cover property (mem_rd);
endmodule
bind spi_eeprom_ctrl spi_eeprom_ctrl_chk #(.WC_CYC(WC_CYC)) i_spi_eeprom_ctrl_chk (
  .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .miso_oe(miso_oe), .write_busy_flag(write_busy_flag),
  .write_enable_latch(write_enable_latch));

/* File: test/spi_master_model.sv */
// Serial bus master model, mode 0, 48 ns clock period
`timescale 1ns/1ps
module spi_master_model (
  output reg       cs_n,
  output reg       sck,
  output reg       mosi,
  input  wire      miso
);
  // Clock stands low between frames
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
  // One selection of n bytes, MSB first; every received bit is kept
  task frame(input integer n, input [47:0] tx, output [47:0] rx);
    integer i;
    begin
      rx = 48'h0000_0000_0000;
      cs_n = 1'b0;
      for (i = 0; i < 8 * n; i = i + 1)
      begin
        mosi = tx[47 - i];
        #24;
        sck = 1'b1;
        rx = {rx[46:0], miso};
        #24;
        sck = 1'b0;
      end
      // Deselect inside the low phase after the last capture
      #10;
      cs_n = 1'b1;
      mosi = ~mosi;
      #60;
    end
  endtask
endmodule

/* File: test/spi_eeprom_ctrl_tb_top.sv */
// Self-checking testbench for the serial EEPROM command controller
`timescale 1ns/1ps
module spi_eeprom_ctrl_tb_top;
  reg         clk_sys   = 1'b0;
  reg         rstn      = 1'b0;
  reg         wp_n      = 1'b1;
  reg  [7:0]  mem_rdata = 8'h00;
  wire        cs_n, sck, mosi, miso, miso_oe, mem_rd, mem_id, mem_wr;
  wire        write_busy_flag, write_enable_latch;
  wire [14:0] mem_addr;
  wire [7:0]  mem_wdata;
  reg  [47:0] rx;
  reg  [22:0] wlog [0:7];   // Address and data of the first 8 array writes
  integer     nw = 0;
  integer     nrd = 0;
  integer     cycles = 0;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Short write cycle keeps polling quick but still outlasts one frame
  spi_eeprom_ctrl #(.WC_CYC(400)) i_spi_eeprom_ctrl (
    .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .wp_n(wp_n), .mem_rdata(mem_rdata), .miso(miso), .miso_oe(miso_oe), .mem_rd(mem_rd),
    .mem_id(mem_id), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .write_busy_flag(write_busy_flag), .write_enable_latch(write_enable_latch));
  spi_master_model i_spi_master_model (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
  ////////////////////////////////////////////////////////////////////////
  // Array model: byte is its low address xor 5Ah, ready one cycle later
  always @(negedge clk_sys)
    if (mem_rd)
      mem_rdata <= mem_addr[7:0] ^ 8'h5a;
  // Log writes and count reads
  always @(posedge clk_sys)
  begin
    if (mem_wr && nw < 8)
      wlog[nw] <= {mem_addr, mem_wdata};
    nw  <= nw + mem_wr;
    nrd <= nrd + mem_rd;
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task check(input [8*8-1:0] nm, input [22:0] exp, input [22:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task f(input integer n, input [47:0] tx);
    i_spi_master_model.frame(n, tx, rx);
  endtask
  // Poll status until the write cycle is over, then compare the status
  task poll(input [7:0] exp);
    integer k;
    begin
      k = 0;
      rx = 48'h0000_0000_0001;
      while (rx[0] !== 1'b0 && k < 40)
      begin
        f(2, {8'h05, 40'h00_0000_0000});
        k = k + 1;
      end
      check("status", exp, rx[7:0]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_latch;
    begin
      check("latch", 0, write_enable_latch);
      f(1, {8'h06, 40'h0});
      check("latch", 1, write_enable_latch);
      f(1, {8'h04, 40'h0});
      check("latch", 0, write_enable_latch);
      $display("test latch done");
    end
  endtask
  task t_status;
    begin
      f(1, {8'h06, 40'h0});
      f(2, {8'h01, 8'hfc, 32'h0});
      check("busy", 1, write_busy_flag);
      f(3, {8'h05, 40'h0});
      check("stat1", 8'h8f, rx[15:8]);
      check("stat2", 8'h8f, rx[7:0]);
      poll(8'h8c);
      @(negedge clk_sys);
      wp_n = 1'b0;
      f(1, {8'h06, 40'h0});
      f(2, {8'h01, 8'h00, 32'h0});
      check("busy", 0, write_busy_flag);
      poll(8'h8e);
      @(negedge clk_sys);
      wp_n = 1'b1;
      f(2, {8'h01, 8'h00, 32'h0});
      check("busy", 1, write_busy_flag);
      poll(8'h00);
      $display("test status done");
    end
  endtask
  task t_read;
    begin
      f(5, {8'h03, 16'hffff, 16'h0000, 8'h00});
      check("rd_top", 8'ha5, rx[15:8]);
      check("rd_wrap", 8'h5a, rx[7:0]);
      check("rd_id", 0, mem_id);
      check("oe", 0, miso_oe);
      $display("test read done");
    end
  endtask
  // Id page read: byte 3Fh of the page, then wrap to the page start
  task t_id;
    integer r;
    begin
      f(5, {8'h83, 16'h017f, 16'h0000, 8'h00});
      check("id_first", 8'h25, rx[15:8]);
      check("id_wrap", 8'h1a, rx[7:0]);
      check("id_sel", 1, mem_id);
      r = nrd;
      f(5, {8'h83, 16'h0400, 16'h0000, 8'h00});
      check("id_a10", r, nrd);
      $display("test id done");
    end
  endtask
  task t_write;
    integer r;
    begin
      f(4, {8'h02, 16'h007e, 8'h11, 16'h0});
      check("busy", 0, write_busy_flag);
      f(1, {8'h06, 40'h0});
      f(6, {8'h02, 16'h807e, 8'ha1, 8'hb2, 8'hc3});
      check("busy", 1, write_busy_flag);
      r = nrd;
      f(5, {8'h03, 16'h0000, 16'h0000, 8'h00});
      check("rd_busy", r, nrd);
      poll(8'h00);
      check("nw", 3, nw);
      check("wr0", {15'h0040, 8'hc3}, wlog[0]);
      check("wr1", {15'h007e, 8'ha1}, wlog[1]);
      check("wr2", {15'h007f, 8'hb2}, wlog[2]);
      f(1, {8'h06, 40'h0});
      f(2, {8'h01, 8'h0c, 32'h0});
      poll(8'h0c);
      f(1, {8'h06, 40'h0});
      f(4, {8'h02, 16'h0010, 8'h55, 16'h0});
      check("busy", 0, write_busy_flag);
      check("nw", 3, nw);
      f(2, {8'h01, 8'h00, 32'h0});
      poll(8'h00);
      $display("test write done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset for 8 cycles, then the scenarios in turn
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_latch;
    t_status;
    t_read;
    t_id;
    t_write;
    end_sim;
  end
endmodule
